/* File: wdk_osc_tick.sv */
// wdk_osc_tick: one-cycle tick at the low-speed oscillator rate
// assumes clk_sys; the tick models the low_speed_rc_osc edge
`timescale 1ns/10ps
`default_nettype none
module wdk_osc_tick #(
    parameter int DIV = 1562                         // sys cycles per tick
) (
    input  wire logic clk_sys,                       // system clock
    input  wire logic rst_n,                         // sync reset, low
    input  wire logic run,                           // clock runs while high
    output logic      tick                           // one-cycle pulse
);
    // ==========================================================
    // divider
    logic [15:0] cnt_r;                              // divide counter
    logic [15:0] cnt_nxt;
    logic        tick_nxt;

    // stopping the count freezes the osc clock, as when disabled
    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (run) begin
            if (cnt_r == 16'(DIV - 1)) begin
                cnt_nxt  = 16'h0000;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: wdk_pkg.sv */
// wdk_pkg: constants for the key-controlled watchdog timer
// assumes a single 50 MHz system clock and an Avalon-MM register slave
package wdk_pkg;
    // ==========================================================
    // register map (byte addresses, one word each)
    localparam logic [3:0] WDK_OFS_CTRL    = 4'h0;   // watchdog_control
    localparam logic [3:0] WDK_OFS_AUX     = 4'h4;   // aux_mode_and_reset_flags
    localparam logic [3:0] WDK_OFS_STAT    = 4'h8;   // event status, read clears
    localparam logic [3:0] WDK_OFS_MASK    = 4'hC;   // event mask
    // ==========================================================
    // reset values and field positions
    localparam logic [7:0] WDK_CTRL_RST    = 8'h53;  // key 01010, select 011
    localparam logic [4:0] WDK_KEY_OFF     = 5'h15;  // 10101 disables
    localparam logic [4:0] WDK_KEY_ON      = 5'h0A;  // 01010 enables
    localparam int         WDK_KEY_LSB     = 3;      // key field bits 7:3
    localparam int         WDK_AUX_KEEP    = 7;      // idle_sysclk_keep
    localparam int         WDK_AUX_RSV3    = 3;      // reserved_bit_three
    localparam int         WDK_AUX_LVR     = 2;      // low_voltage_reset_flag
    localparam int         WDK_AUX_CRF     = 0;      // ctrl_reg_reset_flag
    localparam int         WDK_SEL_BASE    = 8;      // period = 2^(8+sel)
    localparam int         WDK_CNT_W       = 16;     // free-running counter width
    // status / mask bit positions
    localparam int         WDK_EV_KEY      = 0;      // key software reset
    localparam int         WDK_EV_RUN      = 1;      // overflow, normal run
    localparam int         WDK_EV_SLP      = 2;      // overflow in sleep/idle
    // ==========================================================
    // timing
    localparam int         WDK_SYS_HZ      = 50_000_000;
    localparam int         WDK_OSC_HZ      = 32_000; // nominal low-speed osc
    localparam int         WDK_OSC_DIV     = WDK_SYS_HZ / WDK_OSC_HZ; // 1562
    localparam int         WDK_KEY_DLY     = 3;      // osc ticks before key reset, 2-3 periods
endpackage

/* File: wdk_watchdog.sv */
// wdk_watchdog: key-controlled watchdog with reset flags and interrupt
// assumes the cpu core gives clear/halt pulses and a wake pulse
// Overview of operation
// - count low-speed osc ticks, divided 2^8..2^15
// - period 2^(8+select), select resets to 011
// - key 10101 disables, 01010 enables watchdog
// - bad key resets device 2-3 ticks later
// - key reset flag set by hardware only
// - low-voltage flag clears by 0, sets by event
// - unimplemented aux bits read as zero
// - overflow when running resets device, sets expired
// - overflow in sleep sets both, core-only reset
// - counter clears: key reset, pin, clear, halt
// - clear and halt are the instructions that clear counter
// - longest 2^15, shortest 2^8 ticks
// - halt clears counter; disabled stops its clock
// - power-down flag: halt sets, clear resets
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module wdk_watchdog #(
    parameter int OSC_DIV = wdk_pkg::WDK_OSC_DIV     // sys cycles per osc tick
) (
    input  wire logic        clk_sys,                // 50 MHz system clock
    input  wire logic        rst_n,                  // sync reset, low
    input  wire logic        resetPinLow,            // external reset pin low
    input  wire logic        lowVoltEvent,           // low-voltage reset pulse
    input  wire logic        clrWdtExec,             // clear instruction pulse
    input  wire logic        haltExec,               // halt instruction pulse
    input  wire logic        wakeExec,               // core resumed from sleep
    input  wire logic [3:0]  avs_address,            // byte address
    input  wire logic        avs_read,               // read strobe
    input  wire logic        avs_write,              // write strobe
    input  wire logic [31:0] avs_writedata,          // write data
    input  wire logic [3:0]  avs_byteenable,         // byte lanes
    output logic [31:0]      avs_readdata,           // read data
    output logic             avs_waitrequest,        // stall
    output logic             devReset,               // full device reset pulse
    output logic             coreReset,              // pc/stack reset pulse
    output logic             expiredFlag,            // watchdog_expired_flag
    output logic             powerDownFlag,          // power_down_flag
    output logic             irq                     // level interrupt
);
    import wdk_pkg::*;
    // ==========================================================
    // state
    logic [7:0]           ctrl_r, ctrl_nxt;          // watchdog_control
    logic                 keep_r, keep_nxt;          // idle_sysclk_keep
    logic                 rsv3_r, rsv3_nxt;          // reserved_bit_three
    logic                 lvr_r, lvr_nxt;            // low_voltage_reset_flag
    logic                 crf_r, crf_nxt;            // ctrl_reg_reset_flag
    logic [2:0]           stat_r, stat_nxt;          // sticky events
    logic [2:0]           mask_r, mask_nxt;          // event mask
    logic [WDK_CNT_W-1:0] cnt_r, cnt_nxt;            // free-running counter
    logic                 sleep_r, sleep_nxt;        // in sleep/idle
    logic                 keyPend_r, keyPend_nxt;    // bad key seen
    logic [1:0]           keyTk_r, keyTk_nxt;        // ticks since bad key
    logic                 ack_r, ack_nxt;            // bus answer phase
    logic [31:0]          rdata_nxt;
    logic                 devRst_nxt, coreRst_nxt, to_nxt, pdf_nxt, irq_nxt;
    logic                 tick;                      // osc tick
    logic                 enabled;                   // watchdog running
    logic                 keyBad;                    // key not a valid code
    logic                 ovf;                       // selected bit wraps
    logic [WDK_CNT_W-1:0] cntInc;                    // counter plus one

    // true when the key field holds a valid code
    function automatic logic key_valid(input logic [4:0] k);
        key_valid = (k == WDK_KEY_OFF) || (k == WDK_KEY_ON);
    endfunction

    assign keyBad  = !key_valid(ctrl_r[7:WDK_KEY_LSB]);
    assign enabled = (ctrl_r[7:WDK_KEY_LSB] == WDK_KEY_ON);

    // ==========================================================
    // osc tick source, runs while enabled or a bad key is pending
    wdk_osc_tick #(.DIV(OSC_DIV)) u_tick (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .run     (enabled || keyPend_r),
        .tick    (tick)
    );

    // overflow: the bit picked by the select field carries out.
    // bit (7+sel) of the incremented count falls from 1 to 0 every
    // 2^(8+sel) ticks
    assign cntInc = cnt_r + {{(WDK_CNT_W-1){1'b0}}, 1'b1};
    assign ovf = tick && enabled && cnt_r[WDK_SEL_BASE - 1 + int'(ctrl_r[2:0])]
                 && !cntInc[WDK_SEL_BASE - 1 + int'(ctrl_r[2:0])];

    // ==========================================================
    // next-state logic for counter, flags, bus and outputs
    always_comb begin
        ctrl_nxt    = ctrl_r;
        keep_nxt    = keep_r;
        rsv3_nxt    = rsv3_r;
        lvr_nxt     = lvr_r;
        crf_nxt     = crf_r;
        stat_nxt    = stat_r;
        mask_nxt    = mask_r;
        cnt_nxt     = cnt_r;
        sleep_nxt   = sleep_r;
        keyPend_nxt = keyPend_r;
        keyTk_nxt   = keyTk_r;
        ack_nxt     = 1'b0;
        rdata_nxt   = 32'h0000_0000;
        devRst_nxt  = 1'b0;
        coreRst_nxt = 1'b0;
        to_nxt      = expiredFlag;
        pdf_nxt     = powerDownFlag;
        // counting
        if (tick && enabled) begin
            cnt_nxt = cntInc;
        end
        // bus: one wait cycle, then answer in the ack cycle
        if ((avs_read || avs_write) && !ack_r) begin
            ack_nxt = 1'b1;
        end
        if (ack_r && avs_write) begin
            case (avs_address)
                WDK_OFS_CTRL: begin
                    if (avs_byteenable[0]) begin
                        ctrl_nxt = avs_writedata[7:0];
                    end
                end
                WDK_OFS_AUX: begin
                    if (avs_byteenable[0]) begin
                        keep_nxt = avs_writedata[WDK_AUX_KEEP];
                        rsv3_nxt = avs_writedata[WDK_AUX_RSV3];
                        // writes only clear, never set
                        if (!avs_writedata[WDK_AUX_LVR]) begin
                            lvr_nxt = 1'b0;
                        end
                        if (!avs_writedata[WDK_AUX_CRF]) begin
                            crf_nxt = 1'b0;
                        end
                    end
                end
                WDK_OFS_MASK: begin
                    if (avs_byteenable[0]) begin
                        mask_nxt = avs_writedata[2:0];
                    end
                end
                default: begin
                    // unmapped or read-only: ignored
                end
            endcase
        end
        // read data is loaded in the wait cycle so it stands while waitrequest is low
        if (avs_read && !ack_r) begin
            case (avs_address)
                WDK_OFS_CTRL: rdata_nxt[7:0] = ctrl_r;
                WDK_OFS_AUX: begin
                    // bits 6:4 and 1 are not implemented
                    rdata_nxt[WDK_AUX_KEEP] = keep_r;
                    rdata_nxt[WDK_AUX_RSV3] = rsv3_r;
                    rdata_nxt[WDK_AUX_LVR]  = lvr_r;
                    rdata_nxt[WDK_AUX_CRF]  = crf_r;
                end
                WDK_OFS_STAT: rdata_nxt[2:0] = stat_r;
                WDK_OFS_MASK: rdata_nxt[2:0] = mask_r;
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        // read clears only the bits reported, so an event in the wait cycle survives
        if (ack_r && avs_read && (avs_address == WDK_OFS_STAT)) begin
            stat_nxt = stat_r & ~avs_readdata[2:0];
        end
        // clear instruction: one of two instructions clearing the count, with halt
        if (clrWdtExec) begin
            cnt_nxt = '0;
            pdf_nxt = 1'b0;
            to_nxt  = 1'b0;
        end
        // halt: enter sleep, counter cleared and keeps running if on
        if (haltExec) begin
            cnt_nxt   = '0;
            pdf_nxt   = 1'b1;
            to_nxt    = 1'b0;
            sleep_nxt = 1'b1;
        end
        if (wakeExec) begin
            sleep_nxt = 1'b0;
        end
        // bad key: count the set number of ticks, then reset the device
        if (keyBad && !keyPend_r) begin
            keyPend_nxt = 1'b1;
            keyTk_nxt   = 2'b00;
        end else if (keyPend_r && tick) begin
            if (keyTk_r == 2'(WDK_KEY_DLY - 1)) begin
                devRst_nxt  = 1'b1;
                crf_nxt     = 1'b1;
                stat_nxt[WDK_EV_KEY] = 1'b1;
                ctrl_nxt    = WDK_CTRL_RST;
                cnt_nxt     = '0;
                keyPend_nxt = 1'b0;
                sleep_nxt   = 1'b0;
            end else begin
                keyTk_nxt = keyTk_r + 2'b01;
            end
        end
        // overflow: full reset when running, core reset when asleep
        if (ovf) begin
            to_nxt = 1'b1;
            cnt_nxt = '0;
            if (sleep_r) begin
                pdf_nxt     = 1'b1;
                coreRst_nxt = 1'b1;
                sleep_nxt   = 1'b0;
                stat_nxt[WDK_EV_SLP] = 1'b1;
            end else begin
                devRst_nxt  = 1'b1;
                ctrl_nxt    = WDK_CTRL_RST;
                stat_nxt[WDK_EV_RUN] = 1'b1;
            end
        end
        // external reset pin holds the counter clear
        if (resetPinLow) begin
            cnt_nxt = '0;
        end
        // hardware set beats a same-cycle software clear
        if (lowVoltEvent) begin
            lvr_nxt = 1'b1;
        end
        irq_nxt = |(stat_nxt & mask_r);
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_r        <= WDK_CTRL_RST;
            keep_r        <= 1'b0;
            rsv3_r        <= 1'b0;
            lvr_r         <= 1'b0;
            crf_r         <= 1'b0;
            stat_r        <= 3'b000;
            mask_r        <= 3'b000;
            cnt_r         <= '0;
            sleep_r       <= 1'b0;
            keyPend_r     <= 1'b0;
            keyTk_r       <= 2'b00;
            ack_r         <= 1'b0;
            avs_waitrequest <= 1'b1;                                  // stall until answered
            avs_readdata  <= 32'h0000_0000;
            devReset      <= 1'b0;
            coreReset     <= 1'b0;
            expiredFlag   <= 1'b0;
            powerDownFlag <= 1'b0;
            irq           <= 1'b0;
        end else begin
            ctrl_r        <= ctrl_nxt;
            keep_r        <= keep_nxt;
            rsv3_r        <= rsv3_nxt;
            lvr_r         <= lvr_nxt;
            crf_r         <= crf_nxt;
            stat_r        <= stat_nxt;
            mask_r        <= mask_nxt;
            cnt_r         <= cnt_nxt;
            sleep_r       <= sleep_nxt;
            keyPend_r     <= keyPend_nxt;
            keyTk_r       <= keyTk_nxt;
            ack_r         <= ack_nxt;
            avs_waitrequest <= !ack_nxt;                              // low only in answer cycle
            avs_readdata  <= rdata_nxt;
            devReset      <= devRst_nxt;
            coreReset     <= coreRst_nxt;
            expiredFlag   <= to_nxt;
            powerDownFlag <= pdf_nxt;
            irq           <= irq_nxt;
        end
    end

    // ==========================================================
    // checks
    chk_clear_instr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clrWdtExec && !haltExec && !ovf && !(keyPend_r && tick) |=> cnt_r == '0)
        else $error("counter not cleared by clear instruction");
    chk_halt_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
        haltExec && !ovf |=> powerDownFlag && sleep_r)
        else $error("halt did not set power-down");
    chk_clear_pdf: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clrWdtExec && !haltExec && !ovf |=> !powerDownFlag)
        else $error("clear did not drop power-down");
    chk_run_ovf: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ovf && !sleep_r |=> devReset && expiredFlag && !coreReset)
        else $error("run overflow did not reset device");
    chk_sleep_ovf: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ovf && sleep_r |=> coreReset && expiredFlag && powerDownFlag && !devReset)
        else $error("sleep overflow wrong");
    chk_key_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !crf_r && !(keyPend_r && tick) |=> !crf_r)
        else $error("key reset flag set without key reset");
    chk_lvr_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        lowVoltEvent |=> lvr_r)
        else $error("low-voltage flag not set");
    chk_pin_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        resetPinLow |=> cnt_r == '0)
        else $error("pin low did not clear counter");
    chk_off_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !enabled && !keyPend_r && !clrWdtExec && !haltExec && !resetPinLow
        && !ovf |=> $stable(cnt_r))
        else $error("counter moved while disabled");
    chk_key_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(keyPend_r) |-> !devReset [*3])
        else $error("key reset too early");
endmodule
`default_nettype wire

/* File: wdk_watchdog_tb.sv */
// wdk_watchdog_tb: self-checking bench for the key-controlled watchdog
// assumes wdk_pkg and wdk_watchdog are compiled first; bench is the only bus master
`timescale 1ns/10ps
`default_nettype none
module tb;
    import wdk_pkg::*;
    // ==========================================================
    // signals
    localparam int DIV = 4;                  // short osc divider keeps the run small
    logic        clk_sys;                    // 50 MHz system clock
    logic        rst_n;                      // sync reset, low
    logic        resetPinLow;                // external pin low
    logic        lowVoltEvent;               // low-voltage event
    logic        clrWdtExec;                 // clear instruction pulse
    logic        haltExec;                   // halt instruction pulse
    logic        wakeExec;                   // wake pulse
    logic [3:0]  avs_address;                // bus address
    logic        avs_read;                   // read strobe
    logic        avs_write;                  // write strobe
    logic [31:0] avs_writedata;              // write data
    logic [3:0]  avs_byteenable;             // byte lanes
    logic [31:0] avs_readdata;               // read data
    logic        avs_waitrequest;            // stall
    logic        devReset;                   // full reset pulse
    logic        coreReset;                  // pc/stack reset pulse
    logic        expiredFlag;                // time-out flag
    logic        powerDownFlag;              // power-down flag
    logic        irq;                        // level interrupt
    logic [31:0] rdat;                       // last read data
    logic        sawDev;                     // device reset seen by waitEv
    logic        sawCore;                    // core reset seen by waitEv
    int          errTotal;                   // mismatches
    int          cmpCount;                   // comparisons
    int          n;                          // cycles counted by waitEv
    int          p;                          // period in osc ticks
    int          s;                          // select value
    int          k;                          // loop index

    wdk_watchdog #(.OSC_DIV(DIV)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .resetPinLow(resetPinLow),
        .lowVoltEvent(lowVoltEvent), .clrWdtExec(clrWdtExec), .haltExec(haltExec),
        .wakeExec(wakeExec), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .devReset(devReset), .coreReset(coreReset),
        .expiredFlag(expiredFlag), .powerDownFlag(powerDownFlag), .irq(irq)
    );

    // ==========================================================
    // clock: free running, 20 ns period
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // reporting
    task automatic results();
        if (errTotal == 0 && cmpCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // values compared with case equality so an unknown never matches
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmpCount++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // cycle counts: the osc divider phase is free, so a window is allowed
    task automatic chkRange(input string what, input int lo, input int hi, input int got);
        cmpCount++;
        if (got < lo || got > hi) begin
            errTotal++;
            $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // ==========================================================
    // bus cycle: request held until waitrequest is sampled low at an edge
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                       input logic [3:0] be);
        int j;
        @(posedge clk_sys);
        avs_address    <= adr;
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_writedata  <= wd;
        avs_byteenable <= be;
        for (j = 0; j < 20; j++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        rdat = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (j == 20) begin
            errTotal++;
            results();
        end
    endtask

    task automatic wr(input logic [3:0] adr, input logic [31:0] wd);
        bus(1'b1, adr, wd, 4'h1);
    endtask

    task automatic rdChk(input logic [3:0] adr, input logic [31:0] exp, input string what);
        bus(1'b0, adr, 32'h0000_0000, 4'h1);
        chk(what, exp, rdat);
    endtask

    // one-cycle pulse on a core event line; all lines drop together
    task automatic pulse(input int which);
        @(posedge clk_sys);
        case (which)
            0: clrWdtExec <= 1'b1;
            1: haltExec <= 1'b1;
            2: wakeExec <= 1'b1;
            3: lowVoltEvent <= 1'b1;
            default: resetPinLow <= 1'b1;
        endcase
        @(posedge clk_sys);
        {clrWdtExec, haltExec, wakeExec, lowVoltEvent, resetPinLow} <= 5'h00;
        @(posedge clk_sys);
    endtask

    // bounded wait for either reset pulse; n reaches lim when none came
    task automatic waitEv(input int lim);
        for (n = 0; n < lim; n++) begin
            @(posedge clk_sys);
            if (devReset === 1'b1 || coreReset === 1'b1) break;
        end
        sawDev  = devReset;
        sawCore = coreReset;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        errTotal = 0;
        cmpCount = 0;
        rst_n = 1'b0;
        {resetPinLow, lowVoltEvent, clrWdtExec, haltExec, wakeExec} = 5'h00;
        {avs_read, avs_write} = 2'b00;
        avs_address = 4'h0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h1;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset values and refused accesses
        rdChk(WDK_OFS_CTRL, 32'h0000_0053, "ctrl reset");
        rdChk(WDK_OFS_AUX, 32'h0000_0000, "aux reset");
        rdChk(WDK_OFS_STAT, 32'h0000_0000, "status reset");
        rdChk(WDK_OFS_MASK, 32'h0000_0000, "mask reset");
        wr(4'h2, 32'h0000_00A8);
        bus(1'b1, WDK_OFS_CTRL, 32'h0000_00A8, 4'h0);
        rdChk(WDK_OFS_CTRL, 32'h0000_0053, "ctrl untouched");
        rdChk(4'h2, 32'h0000_0000, "unmapped read");
        // aux flags: write-one ignored on flags, unimplemented bits zero
        wr(WDK_OFS_AUX, 32'h0000_00FF);
        rdChk(WDK_OFS_AUX, 32'h0000_0088, "aux ones");
        pulse(3);
        rdChk(WDK_OFS_AUX, 32'h0000_008C, "lvr set");
        wr(WDK_OFS_AUX, 32'h0000_0004);
        rdChk(WDK_OFS_AUX, 32'h0000_0004, "lvr kept");
        wr(WDK_OFS_AUX, 32'h0000_0000);
        rdChk(WDK_OFS_AUX, 32'h0000_0000, "lvr cleared");
        // disable key: no overflow at the shortest period
        wr(WDK_OFS_CTRL, 32'h0000_00A8);
        pulse(0);
        waitEv(3000);
        chkRange("disabled quiet", 3000, 3000, n);
        rdChk(WDK_OFS_CTRL, 32'h0000_00A8, "ctrl disabled");
        // overflow time for the three shortest selects
        for (s = 0; s < 3; s++) begin
            p = 1 << (WDK_SEL_BASE + s);
            pulse(0);
            wr(WDK_OFS_CTRL, {24'h00_0000, WDK_KEY_ON, s[2:0]});
            pulse(0);
            waitEv(p * DIV + 4 * DIV);
            chkRange("overflow time", (p - 1) * DIV, p * DIV + DIV + 2, n);
            chk("device reset", 32'h0000_0001, {31'h0, sawDev});
            chk("expired", 32'h0000_0001, {31'h0, expiredFlag});
            rdChk(WDK_OFS_CTRL, 32'h0000_0053, "ctrl reload");
            rdChk(WDK_OFS_STAT, 32'h0000_0002, "run status");
        end
        // regular clearing keeps it alive
        wr(WDK_OFS_CTRL, 32'h0000_0050);
        pulse(0);
        chk("expired cleared", 32'h0000_0000, {31'h0, expiredFlag});
        for (k = 0; k < 4; k++) begin
            waitEv(700);
            chkRange("cleared quiet", 700, 700, n);
            pulse(0);
        end
        // reset pin restarts the count
        waitEv(700);
        pulse(4);
        waitEv(260 * DIV);
        chkRange("pin clears", 255 * DIV, 257 * DIV + 2, n);
        rdChk(WDK_OFS_STAT, 32'h0000_0002, "pin status");
        // halt: sleep overflow resets the core only
        wr(WDK_OFS_CTRL, 32'h0000_0050);
        pulse(0);
        waitEv(500);
        pulse(1);
        chk("pdf on halt", 32'h0000_0001, {31'h0, powerDownFlag});
        chk("expired on halt", 32'h0000_0000, {31'h0, expiredFlag});
        waitEv(260 * DIV);
        chkRange("sleep overflow", 255 * DIV, 257 * DIV + 2, n);
        chk("core reset", 32'h0000_0001, {31'h0, sawCore});
        chk("no dev reset", 32'h0000_0000, {31'h0, sawDev});
        chk("sleep expired", 32'h0000_0001, {31'h0, expiredFlag});
        chk("sleep pdf", 32'h0000_0001, {31'h0, powerDownFlag});
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        rdChk(WDK_OFS_STAT, 32'h0000_0004, "sleep status");
        pulse(2);
        pulse(0);
        chk("pdf cleared", 32'h0000_0000, {31'h0, powerDownFlag});
        // bad key: delayed reset, sticky flag, interrupt
        wr(WDK_OFS_MASK, 32'h0000_0001);
        rdChk(WDK_OFS_MASK, 32'h0000_0001, "mask rw");
        wr(WDK_OFS_CTRL, 32'h0000_00FB);
        waitEv(6 * DIV);
        chkRange("key reset delay", 2 * DIV, 3 * DIV + 4, n);
        chk("key dev reset", 32'h0000_0001, {31'h0, sawDev});
        repeat (2) @(posedge clk_sys);
        chk("irq set", 32'h0000_0001, {31'h0, irq});
        rdChk(WDK_OFS_AUX, 32'h0000_0001, "crf set");
        rdChk(WDK_OFS_CTRL, 32'h0000_0053, "ctrl after key");
        rdChk(WDK_OFS_STAT, 32'h0000_0001, "key status");
        rdChk(WDK_OFS_STAT, 32'h0000_0000, "status read clear");
        repeat (2) @(posedge clk_sys);
        chk("irq clear", 32'h0000_0000, {31'h0, irq});
        wr(WDK_OFS_AUX, 32'h0000_0001);
        rdChk(WDK_OFS_AUX, 32'h0000_0001, "crf kept");
        wr(WDK_OFS_AUX, 32'h0000_0000);
        rdChk(WDK_OFS_AUX, 32'h0000_0000, "crf cleared");
        results();
    end
endmodule
`default_nettype wire
